// ===== hdl/init_value_cell.sv
`timescale 1ns/1ns
`default_nettype none

module init_value_cell #(
	parameter reset_init_pkg::cell_cfg_t CFG = '0
) (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_por,
	input  wire logic       i_oth,
	input  wire logic       i_wake,
	input  wire logic       i_we,
	input  wire logic [7:0] i_wdata,
	input  wire logic [7:0] i_cond,
	output logic      [7:0] o_q
);

	reset_init_pkg::cell_state_t q;
	reset_init_pkg::cell_state_t d;

	// ****************************************************************
	// reset cause beats a software write landing in the same cycle
	// ****************************************************************
	always_comb begin
		d = q;
		if (i_por) begin
			d.val = (q.val & ~(CFG.por_l | CFG.por_q)) | (CFG.por_v & CFG.por_l)
				| (i_cond & CFG.por_q);
		end else if (i_oth) begin
			d.val = (q.val & ~(CFG.oth_l | CFG.oth_q)) | (CFG.oth_v & CFG.oth_l)
				| (i_cond & CFG.oth_q);
		end else if (i_wake) begin
			d.val = (q.val & ~(CFG.wk_l | CFG.wk_q)) | (CFG.wk_v & CFG.wk_l)
				| (i_cond & CFG.wk_q);
		end else if (i_we) begin
			d.val = i_wdata;
		end
		// unimplemented bits never hold a one
		d.val = d.val & CFG.impl;
	end

	// undefined bits settle to zero under the pin reset, a safe known value
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			q.val <= CFG.por_v & CFG.impl;
		end else begin
			q <= d;
		end
	end

	assign o_q = q.val;

endmodule : init_value_cell

`default_nettype wire

// ===== hdl/reset_init_pkg.sv
package reset_init_pkg;

	typedef struct packed {
		logic [7:0] impl;
		logic [7:0] por_l;
		logic [7:0] por_v;
		logic [7:0] por_q;
		logic [7:0] oth_l;
		logic [7:0] oth_v;
		logic [7:0] oth_q;
		logic [7:0] wk_l;
		logic [7:0] wk_v;
		logic [7:0] wk_q;
	} cell_cfg_t;

	typedef struct packed {
		logic [7:0] val;
	} cell_state_t;

	typedef struct packed {
		logic [7:0]  sp;
		logic [20:0] tos;
		logic [7:0]  latch;
		logic [7:0]  dir;
		logic [7:0]  oe;
		logic [7:0]  pins_s1;
		logic [7:0]  pins_s2;
		logic [7:0]  irq_req;
		logic [7:0]  ev_st;
		logic [7:0]  ev_en;
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
		logic        vec_load;
		logic [20:0] vec;
		logic        irq;
	} bank_state_t;

endpackage : reset_init_pkg

// ===== hdl/reset_init_regs.svh
`ifndef RESET_INIT_REGS_SVH
`define RESET_INIT_REGS_SVH

// ****************************************************************
// register window layout (byte addresses on the register bus)
// ****************************************************************
`define CELL_COUNT        24
`define CELL_STRIDE       8'h04
`define IDX_OSCILLATOR    9
`define IDX_RESET_CAUSE   12
`define OFS_STACK_PTR     8'h60
`define OFS_STACK_LOW     8'h64
`define OFS_STACK_HIGH    8'h68
`define OFS_STACK_UPPER   8'h6C
`define OFS_LAST_VECTOR   8'h70
`define OFS_PORT_LATCH    8'h74
`define OFS_PORT_DIR      8'h78
`define OFS_PORT_PINS     8'h7C
`define OFS_IRQ_REQUEST   8'h80
`define OFS_EV_STATUS     8'h84
`define OFS_EV_ENABLE     8'h88
`define OFS_EV_CLEAR      8'h8C

// ****************************************************************
// per-register init tables, bytes from the top:
// impl, por load, por value, por cond, other load, other value,
// other cond, wake load, wake value, wake cond
// ****************************************************************
`define CFG_PTR1_HIGH     80'h0F_000000_000000_000000
`define CFG_PTR1_LOW      80'hFF_000000_000000_000000
`define CFG_BANK_SELECT   80'h0F_0F0000_0F0000_000000
`define CFG_PTR2_HIGH     80'h0F_000000_000000_000000
`define CFG_PTR2_LOW      80'hFF_000000_000000_000000
`define CFG_STATUS        80'h1F_000000_000000_000000
`define CFG_T0_HIGH       80'hFF_FF0000_FF0000_000000
`define CFG_T0_LOW        80'hFF_000000_000000_000000
`define CFG_T0_CONTROL    80'hFF_FFFF00_FFFF00_000000
`define CFG_OSC_CONTROL   80'hFF_F76008_F76008_000008
`define CFG_DISP_REG      80'h7F_7F3C00_7F3800_000000
`define CFG_WDOG_CONTROL  80'h03_030000_030000_000000
`define CFG_RESET_CAUSE   80'hBF_BD3C02_A0001C_00000C
`define CFG_T1_HIGH       80'hFF_000000_000000_000000
`define CFG_T1_LOW        80'hFF_000000_000000_000000
`define CFG_T1_CONTROL    80'hFF_FF0000_400000_000000
`define CFG_T2_COUNT      80'hFF_FF0000_FF0000_000000
`define CFG_T2_PERIOD     80'hFF_FFFF00_FFFF00_FFFF00
`define CFG_T2_CONTROL    80'h7F_7F0000_7F0000_000000
`define CFG_SER_BUFFER    80'hFF_000000_000000_000000
`define CFG_SER_ADDRESS   80'hFF_FF0000_FF0000_000000
`define CFG_SER_STATUS    80'hFF_FF0000_FF0000_000000
`define CFG_SER_CONTROL_A 80'hFF_FF0000_FF0000_000000
`define CFG_SER_CONTROL_B 80'hFF_FF0000_FF0000_000000

// ****************************************************************
// stack, vectors, port and events
// ****************************************************************
`define SP_IMPL           8'hDF
`define SP_KEEP_POR       8'hC0
`define SP_FULL_BIT       7
`define SP_PTR_MAX        5'h1F
`define VEC_HIGH          21'h000008
`define VEC_LOW           21'h000018
`define PORT_OSC_BITS     8'hC0
`define PORT_DIR_RESET    8'hFF
`define PORT_LATCH_RESET  8'h00
`define EV_POR            0
`define EV_OTHER_RESET    1
`define EV_WAKE_WDT       2
`define EV_WAKE_IRQ       3
`define EV_STACK_FULL     4
`define EV_STATUS_RESET   8'h01

`endif

// ===== hdl/reset_init_values_bank.sv
// Contract
// - irq wake with gie pushes pc, bumps pointer
// - irq wake with gie loads 0008h/0018h vector
// - wake leaves source flags in request register
// - port bits 6,7 exist only when oscillator frees
// - unimplemented bits read zero; cond bits from cause
// - bank select clears on resets, kept on wake
// - pointers, status, timer1, buffer: undefined then kept
// - timer0 high clears on resets; low undefined, kept
// - timer0 control sets all ones on resets
// - oscillator control 0110q000; wake changes bit3 only
// - regulator -0111100 on power-on, -0111000 on other resets
// - reset control per cause, cond bits record cause
// - timer1 control clears; other resets clear bit6
// - timer2 clears, period reads ones on all
// - serial address/status/controls clear on resets, kept
// - stack pointer keeps flags on power-on, clears on other resets
`timescale 1ns/1ns
`default_nettype none
`include "reset_init_regs.svh"

module reset_init_values_bank (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        i_por_bor,
	input  wire logic        i_other_reset,
	input  wire logic        i_wake_wdt,
	input  wire logic        i_wake_irq,
	input  wire logic        i_wake_irq_high,
	input  wire logic [7:0]  i_wake_src,
	input  wire logic        i_low_prio_global_irq_enable,
	input  wire logic        i_high_prio_global_irq_enable,
	input  wire logic [20:0] i_pc,
	input  wire logic        i_osc_cond,
	input  wire logic [7:0]  i_reset_cause_cond,
	input  wire logic        i_osc_frees_port_bits,
	input  wire logic [7:0]  i_first_port_pins,
	output logic      [7:0]  o_first_port_latch,
	output logic      [7:0]  o_first_port_oe,
	output logic             o_vector_load,
	output logic      [20:0] o_vector,
	output logic             o_irq
);

	// ****************************************************************
	// init table for the byte registers, in address order
	// ****************************************************************
	localparam reset_init_pkg::cell_cfg_t CELL_CFG [`CELL_COUNT] = '{
		`CFG_PTR1_HIGH,
		`CFG_PTR1_LOW,
		`CFG_BANK_SELECT,
		`CFG_PTR2_HIGH,
		`CFG_PTR2_LOW,
		`CFG_STATUS,
		`CFG_T0_HIGH,
		`CFG_T0_LOW,
		`CFG_T0_CONTROL,
		`CFG_OSC_CONTROL,
		`CFG_DISP_REG,
		`CFG_WDOG_CONTROL,
		`CFG_RESET_CAUSE,
		`CFG_T1_HIGH,
		`CFG_T1_LOW,
		`CFG_T1_CONTROL,
		`CFG_T2_COUNT,
		`CFG_T2_PERIOD,
		`CFG_T2_CONTROL,
		`CFG_SER_BUFFER,
		`CFG_SER_ADDRESS,
		`CFG_SER_STATUS,
		`CFG_SER_CONTROL_A,
		`CFG_SER_CONTROL_B
	};

	// power-on image of the local words: the event status starts with the
	// power-on event set, so software can tell why the part came up
	localparam reset_init_pkg::bank_state_t STATE_RESET = '{
		sp:       8'h00,
		tos:      21'h000000,
		latch:    `PORT_LATCH_RESET,
		dir:      `PORT_DIR_RESET,
		oe:       8'h00,
		pins_s1:  8'h00,
		pins_s2:  8'h00,
		irq_req:  8'h00,
		ev_st:    `EV_STATUS_RESET,
		ev_en:    8'h00,
		rdata:    32'h00000000,
		ready:    1'b0,
		slverr:   1'b0,
		vec_load: 1'b0,
		vec:      21'h000000,
		irq:      1'b0
	};

	reset_init_pkg::bank_state_t q;
	reset_init_pkg::bank_state_t d;

	logic [7:0] cell_q  [`CELL_COUNT];
	logic       wr_cell;
	logic [4:0] wr_idx;
	logic       bus_wr;
	logic       setup;
	logic       gie;
	logic       vec_wake;
	logic       any_wake;
	logic [7:0] port_mask;

	// ****************************************************************
	// bus decode helpers
	// ****************************************************************
	// zero wait state: ready rises with the access phase, so the write
	// commits on the edge where the master sees pready high
	assign setup    = psel & ~penable;
	assign bus_wr   = psel & penable & pwrite & q.ready & ~q.slverr;
	assign wr_cell  = bus_wr && (paddr < (`CELL_STRIDE * 8'(`CELL_COUNT)))
		&& (paddr[1:0] == 2'b00);
	assign wr_idx   = paddr[6:2];
	assign gie      = i_low_prio_global_irq_enable | i_high_prio_global_irq_enable;
	assign any_wake = i_wake_wdt | i_wake_irq;
	// a reset in the same cycle outranks the wake, so nothing is pushed
	assign vec_wake = i_wake_irq & gie & ~i_por_bor & ~i_other_reset;
	assign port_mask = i_osc_frees_port_bits ? 8'hFF : ~`PORT_OSC_BITS;

	// ****************************************************************
	// byte registers with their per-cause init values
	// ****************************************************************
	// one cell per register keeps the cause priority in one place;
	// the table above carries ..as load/cond masks
	genvar gi;
	generate
		for (gi = 0; gi < `CELL_COUNT; gi = gi + 1) begin : g_cell
			logic [7:0] cond;
			if (gi == `IDX_RESET_CAUSE) begin : g_rc
				assign cond = i_reset_cause_cond;
			end else if (gi == `IDX_OSCILLATOR) begin : g_osc
				assign cond = {4'h0, i_osc_cond, 3'h0};
			end else begin : g_none
				assign cond = 8'h00;
			end
			init_value_cell #(
				.CFG (CELL_CFG[gi])
			) u_cell (
				.i_mclk  (i_mclk),
				.i_rst   (i_rst),
				.i_por   (i_por_bor),
				.i_oth   (i_other_reset),
				.i_wake  (any_wake),
				.i_we    (wr_cell && (wr_idx == 5'(gi))),
				.i_wdata (pwdata[7:0]),
				.i_cond  (cond),
				.o_q     (cell_q[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		logic [7:0]  rd;
		logic [4:0]  ptr;
		logic        hit;
		logic        ro;
		rd  = 8'h00;
		ptr = q.sp[4:0];
		hit = 1'b1;
		ro  = 1'b0;
		d   = q;

		// pins pass two flops before anything reads them
		d.pins_s1 = i_first_port_pins;
		d.pins_s2 = q.pins_s1;
		d.vec_load = 1'b0;

		// ****************************************************************
		// bus writes to the local registers
		// ****************************************************************
		// writes to read-only words fall through and change nothing
		if (bus_wr) begin
			if (paddr == `OFS_STACK_PTR) begin
				d.sp = pwdata[7:0] & `SP_IMPL;
			end else if (paddr == `OFS_STACK_LOW) begin
				d.tos[7:0] = pwdata[7:0];
			end else if (paddr == `OFS_STACK_HIGH) begin
				d.tos[15:8] = pwdata[7:0];
			end else if (paddr == `OFS_STACK_UPPER) begin
				d.tos[20:16] = pwdata[4:0];
			end else if (paddr == `OFS_PORT_LATCH) begin
				d.latch = pwdata[7:0] & port_mask;
			end else if (paddr == `OFS_PORT_DIR) begin
				d.dir = pwdata[7:0] | ~port_mask;
			end else if (paddr == `OFS_IRQ_REQUEST) begin
				d.irq_req = pwdata[7:0];
			end else if (paddr == `OFS_EV_ENABLE) begin
				d.ev_en = pwdata[7:0];
			end else if (paddr == `OFS_EV_CLEAR) begin
				d.ev_st = q.ev_st & ~pwdata[7:0];
			end
		end

		// ****************************************************************
		// reset causes and wake-up
		// ****************************************************************
		// a reset in the same cycle beats a wake; the wake is then dropped
		if (i_por_bor) begin
			d.sp      = q.sp & `SP_KEEP_POR;
			d.tos     = 21'h000000;
			d.irq_req = 8'h00;
			d.latch   = `PORT_LATCH_RESET;
			d.dir     = `PORT_DIR_RESET;
		end else if (i_other_reset) begin
			d.sp      = 8'h00;
			d.tos     = 21'h000000;
			d.irq_req = 8'h00;
			d.latch   = `PORT_LATCH_RESET;
			d.dir     = `PORT_DIR_RESET;
		end else if (any_wake) begin
			// source flags set even if software clears them this cycle
			d.irq_req = d.irq_req | i_wake_src;
			if (vec_wake) begin
				d.tos = i_pc;
				if (ptr == `SP_PTR_MAX) begin
					// no room left: flag it, pointer stays put
					d.sp[`SP_FULL_BIT] = 1'b1;
				end else begin
					d.sp[4:0] = ptr + 5'h01;
				end
				d.vec_load = 1'b1;
				d.vec      = i_wake_irq_high ? `VEC_HIGH : `VEC_LOW;
			end
		end

		// bits that the oscillator mode takes away stay quiet
		// a hidden pin reads zero and is never driven, whatever was written
		d.latch = d.latch & port_mask;
		d.dir   = d.dir | ~port_mask;
		d.oe    = ~d.dir & port_mask;

		// ****************************************************************
		// sticky events, set wins over a clear
		// ****************************************************************
		// a reset and a wake in one cycle log only the reset
		if (i_por_bor) begin
			d.ev_st[`EV_POR] = 1'b1;
		end
		if (i_other_reset) begin
			d.ev_st[`EV_OTHER_RESET] = 1'b1;
		end
		if (i_wake_wdt && !i_por_bor && !i_other_reset) begin
			d.ev_st[`EV_WAKE_WDT] = 1'b1;
		end
		if (i_wake_irq && !i_por_bor && !i_other_reset) begin
			d.ev_st[`EV_WAKE_IRQ] = 1'b1;
		end
		if (vec_wake && ptr == `SP_PTR_MAX) begin
			d.ev_st[`EV_STACK_FULL] = 1'b1;
		end
		// level output: stays up until software clears or masks the bit
		d.irq = |(d.ev_st & d.ev_en);

		// ****************************************************************
		// bus read path, captured in the setup cycle
		// ****************************************************************
		// misaligned words are refused outright
		if (paddr[1:0] != 2'b00) begin
			hit = 1'b0;
		end else if (paddr < (`CELL_STRIDE * 8'(`CELL_COUNT))) begin
			rd = cell_q[paddr[6:2]];
		end else if (paddr == `OFS_STACK_PTR) begin
			rd = q.sp & `SP_IMPL;
		end else if (paddr == `OFS_STACK_LOW) begin
			rd = q.tos[7:0];
		end else if (paddr == `OFS_STACK_HIGH) begin
			rd = q.tos[15:8];
		end else if (paddr == `OFS_STACK_UPPER) begin
			rd = {3'h0, q.tos[20:16]};
		end else if (paddr == `OFS_LAST_VECTOR) begin
			rd = q.vec[7:0];
			ro = 1'b1;
		end else if (paddr == `OFS_PORT_LATCH) begin
			rd = q.latch & port_mask;
		end else if (paddr == `OFS_PORT_DIR) begin
			rd = q.dir & port_mask;
		end else if (paddr == `OFS_PORT_PINS) begin
			rd = q.pins_s2 & port_mask;
			ro = 1'b1;
		end else if (paddr == `OFS_IRQ_REQUEST) begin
			rd = q.irq_req;
		end else if (paddr == `OFS_EV_STATUS) begin
			rd = q.ev_st;
			ro = 1'b1;
		end else if (paddr == `OFS_EV_ENABLE) begin
			rd = q.ev_en;
		end else if (paddr == `OFS_EV_CLEAR) begin
			rd = 8'h00;
		end else begin
			hit = 1'b0;
		end

		// a write to a read-only word is answered with an error
		// one answer per setup, so back-to-back transfers need no idle gap
		d.ready  = setup;
		d.slverr = setup & (~hit | (ro & pwrite));
		// a refused read answers zero rather than the decoded byte
		if (setup) begin
			d.rdata = (hit && !pwrite) ? {24'h000000, rd} : 32'h00000000;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	// async reset gives the power-on image; causes arrive as sync pulses
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			q <= STATE_RESET;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// outputs, each straight from a flop
	// ****************************************************************
	assign prdata             = q.rdata;
	assign pready             = q.ready;
	assign pslverr            = q.slverr;
	assign o_first_port_latch = q.latch;
	assign o_first_port_oe    = q.oe;
	assign o_vector_load      = q.vec_load;
	assign o_vector           = q.vec;
	assign o_irq              = q.irq;

endmodule : reset_init_values_bank

`default_nettype wire

// ===== verification/reset_init_values_bank_checker.sv
`timescale 1ns/1ns
`default_nettype none

module reset_init_values_bank_checker (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic        i_por_bor,
	input  wire logic        i_other_reset,
	input  wire logic        i_wake_irq,
	input  wire logic        i_wake_irq_high,
	input  wire logic        i_low_prio_global_irq_enable,
	input  wire logic        i_high_prio_global_irq_enable,
	input  wire logic        i_osc_frees_port_bits,
	input  wire logic [7:0]  o_first_port_latch,
	input  wire logic [7:0]  o_first_port_oe,
	input  wire logic        o_vector_load,
	input  wire logic [20:0] o_vector
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	logic irq_wake;

	// a reset in the same cycle outranks the wake, so it is left out
	assign irq_wake = i_wake_irq & ~i_por_bor & ~i_other_reset
		& (i_low_prio_global_irq_enable | i_high_prio_global_irq_enable);

	// ****************
	// bus
	// ****************
	a_setup_answered: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	a_err_unmapped: assert property (psel && !penable && (paddr > 8'h8C || paddr[1:0] != 2'h0)
		|=> pready && pslverr) else $error("no error for bad address");
	a_no_err_mapped: assert property (psel && !penable && paddr <= 8'h60 && paddr[1:0] == 2'h0
		|=> !pslverr) else $error("error on a mapped register");
	a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");

	// ****************
	// wake and port
	// ****************
	a_vec_on_wake: assert property (irq_wake |=> o_vector_load
		&& o_vector == ($past(i_wake_irq_high) ? 21'h000008 : 21'h000018))
		else $error("wrong vector after wake");
	a_vec_only_wake: assert property (!irq_wake |=> !o_vector_load)
		else $error("vector load without qualified wake");
	a_vec_held: assert property (!o_vector_load |-> $stable(o_vector))
		else $error("vector changed without load");
	a_port_hidden: assert property (!i_osc_frees_port_bits [*2] |->
		o_first_port_latch[7:6] == 2'h0 && o_first_port_oe[7:6] == 2'h0)
		else $error("hidden port bits active");

	cover property (irq_wake);
	cover property (pready && pslverr);
	cover property (!i_osc_frees_port_bits [*2]);
endmodule : reset_init_values_bank_checker

`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic        i_mclk = 1'h0;
	logic        i_rst = 1'h1;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        i_por_bor = 1'h0;
	logic        i_other_reset = 1'h0;
	logic        i_wake_wdt = 1'h0;
	logic        i_wake_irq = 1'h0;
	logic        i_wake_irq_high = 1'h0;
	logic [7:0]  i_wake_src = 8'h00;
	logic        i_low_prio_global_irq_enable = 1'h0;
	logic        i_high_prio_global_irq_enable = 1'h0;
	logic [20:0] i_pc = 21'h0;
	logic        i_osc_cond = 1'h0;
	logic [7:0]  i_reset_cause_cond = 8'h00;
	logic        i_osc_frees_port_bits = 1'h0;
	logic [7:0]  i_first_port_pins = 8'hA5;
	logic [7:0]  o_first_port_latch;
	logic [7:0]  o_first_port_oe;
	logic        o_vector_load;
	logic [20:0] o_vector;
	logic        o_irq;
	int          n_mismatch = 0;
	int          total_checks = 0;
	logic [31:0] rd;
	logic        er;
	// ****************
	// expected bytes, register 24 (stack pointer) on the left
	// ****************
	logic [199:0] e_imp = 200'hDFFFFFFFFF_FF7FFFFFFF_FFFFBF037F_FFFFFFFF1F_FF0F0FFF0F;
	logic [199:0] e_rst = 200'h0000000000_0000FF0000_00003C003C_60FF000000_0000000000;
	logic [199:0] e_por = 200'hC000000000_FF00FF0000_FFFF3E003C_68FFFF001F_FF0F00FF0F;
	logic [199:0] e_oth = 200'h0000000000_FF00FF00BF_FFFF1F0038_68FFFF001F_FF0F00FF0F;
	logic [199:0] e_wak = 200'hDFFFFFFFFF_FF7FFFFFFF_FFFFB3037F_F7FFFFFF1F_FF0F0FFF0F;

	reset_init_values_bank reset_init_values_bank_i (.*);

	always #25 i_mclk = ~i_mclk;

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// psel stays up at the end so a setup may follow at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_mclk);
		penable <= 1'h1;
		// no cycle limit here: a slave that never answers is caught by the watchdog
		do begin
			@(posedge i_mclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
	endtask : apb

	task automatic idle;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : idle

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk($sformatf("addr %h", a), rd, e);
	endtask : rc

	task automatic bank(input logic [199:0] e);
		for (int i = 0; i < 25; i++)
			rc(8'(4 * i), {24'h0, e[8 * i +: 8]});
	endtask : bank

	// k: 0 power-on, 1 other reset, 2 watchdog wake, 3 interrupt wake
	task automatic pulse(input int k);
		idle();
		i_osc_cond <= (k != 2);
		i_reset_cause_cond <= (k == 2) ? 8'h00 : 8'hFF;
		{i_wake_irq, i_wake_wdt, i_other_reset, i_por_bor} <= 4'(1 << k);
		@(posedge i_mclk);
		{i_wake_irq, i_wake_wdt, i_other_reset, i_por_bor} <= 4'h0;
		@(posedge i_mclk);
	endtask : pulse

	task automatic irqchk(input logic e);
		idle();
		repeat (2) @(posedge i_mclk);
		chk("irq line", {31'h0, o_irq}, {31'h0, e});
	endtask : irqchk

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	initial begin
		#(50 * 4000);
		n_mismatch++;
		results();
	end

	initial begin
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'h0;
		@(posedge i_mclk);
		bank(e_rst);
		$display("reset values done");
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 25; i++)
				apb(1'h1, 8'(4 * i), 32'hFF);
			bank(e_imp);
			pulse(k);
			bank(k == 0 ? e_por : k == 1 ? e_oth : e_wak);
			$display("cause %0d done", k);
		end
		apb(1'h1, 8'h60, 32'h0);
		apb(1'h1, 8'h8C, 32'h1F);
		for (int k = 0; k < 3; k++) begin
			i_high_prio_global_irq_enable <= (k == 0);
			i_low_prio_global_irq_enable <= (k == 1);
			i_wake_irq_high <= (k == 0);
			i_pc <= 21'h012345 + 21'(k);
			i_wake_src <= 8'h24;
			pulse(3);
			rc(8'h60, (k == 2) ? 32'h2 : 32'(k + 1));
			rc(8'h64, (k == 2) ? 32'h46 : 32'h45 + 32'(k));
			rc(8'h68, 32'h23);
			rc(8'h6C, 32'h01);
			rc(8'h70, (k == 0) ? 32'h08 : 32'h18);
			chk("vector", {11'h0, o_vector}, (k == 0) ? 32'h8 : 32'h18);
		end
		rc(8'h80, 32'h24);
		rc(8'h84, 32'h08);
		$display("interrupt wake done");
		apb(1'h1, 8'h88, 32'h08);
		irqchk(1'h1);
		apb(1'h1, 8'h88, 32'h00);
		irqchk(1'h0);
		apb(1'h1, 8'h88, 32'h08);
		apb(1'h1, 8'h8C, 32'h08);
		irqchk(1'h0);
		rc(8'h84, 32'h0);
		apb(1'h0, 8'hF0, 32'h0);
		chk("unmapped error", {31'h0, er}, 32'h1);
		apb(1'h1, 8'h70, 32'h55);
		chk("read-only error", {31'h0, er}, 32'h1);
		rc(8'h70, 32'h18);
		apb(1'h1, 8'h60, 32'h1F);
		i_high_prio_global_irq_enable <= 1'h1;
		pulse(3);
		rc(8'h60, 32'h9F);
		rc(8'h84, 32'h18);
		$display("events and errors done");
		apb(1'h1, 8'h74, 32'hFF);
		apb(1'h1, 8'h78, 32'h00);
		rc(8'h74, 32'h3F);
		rc(8'h7C, 32'h25);
		chk("port latch", {24'h0, o_first_port_latch}, 32'h3F);
		chk("port oe", {24'h0, o_first_port_oe}, 32'h3F);
		i_osc_frees_port_bits <= 1'h1;
		apb(1'h1, 8'h74, 32'hFF);
		rc(8'h74, 32'hFF);
		rc(8'h7C, 32'hA5);
		idle();
		$display("port done");
		i_rst <= 1'h1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'h0;
		@(posedge i_mclk);
		bank(e_rst);
		idle();
		$display("mid-run reset done");
		results();
	end
endmodule : tb_top

bind reset_init_values_bank reset_init_values_bank_checker reset_init_values_bank_checker_i (.*);

`default_nettype wire
